/* File: logic/cosc_ctrl.sv */
// Purpose: calibration, lock report, output dividers, delays and sync of a clock synthesizer
// Assumes: APB slave, 100 MHz clock, cfg_cs_n and sync_pin are asynchronous pins
// Notes:   one clk cycle stands for one prescaler output period
//
// Notes on behaviour
// - rising chip select after config writes starts calibration, then lock is acquired.
// - lock shows as status bit reading 1 and lock pin driven low.
// - each delay unit postpones an output by exactly one prescaler period.
// - delays are non-negative integers that only postpone an output.
// - new delays take effect only at the next synchronization event.
// - outputs with sync disabled ignore sync events entirely.
// - sync off and mute off output keeps toggling through calibration.
// - power down mode gates the output buffer while its divider keeps counting.
// - calibrate bit clears itself when calibration finishes.
`timescale 1ns/1ps
module cosc_ctrl
(
  input  wire logic               clk,
  input  wire logic               sys_rst,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire cosc_pkg::cosc_addr_t paddr,
  input  wire cosc_pkg::cosc_word_t pwdata,
  output logic                    pready,
  output cosc_pkg::cosc_word_t    prdata,
  output logic                    pslverr,
  input  wire logic               cfg_cs_n,
  input  wire logic               sync_pin,
  output cosc_pkg::cosc_outs_t    clk_out,
  output logic                    lock_n,
  output logic                    ref_gain_boost,
  output logic                    ref_input_lowpass,
  output logic                    irq
);
  import cosc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // state
  typedef struct packed {
    cosc_byte_t              ctrl;
    logic [NUM_OUT-1:0][7:0] cfg;
    logic [NUM_EV-1:0]       irq_stat;
    logic [NUM_EV-1:0]       irq_en;
    cosc_loop_t              loop;
    logic [11:0]             tmr;
    logic                    cs_s1;
    logic                    cs_s2;
    logic                    cs_prev;
    logic                    sy_s1;
    logic                    sy_s2;
    logic                    sync_prev;
    logic                    wrote;
    logic [NUM_OUT-1:0][7:0] cnt;
    logic [NUM_OUT-1:0][7:0] hold;
    cosc_outs_t              ph;
    cosc_outs_t              out;
    logic                    pready;
    cosc_word_t              prdata;
    logic                    pslverr;
    logic                    lock_n;
    logic                    irq;
  } cosc_state_t;

  localparam cosc_state_t ST_RST = '{
    ctrl: CTRL_RST, cfg: {NUM_OUT{OUT_CFG_RST}}, irq_stat: '0, irq_en: '0,
    loop: ST_UNLOCKED, tmr: 12'h000, cs_s1: 1'b1, cs_s2: 1'b1, cs_prev: 1'b1,
    sy_s1: 1'b0, sy_s2: 1'b0, sync_prev: 1'b0, wrote: 1'b0, cnt: '0, hold: '0,
    ph: '0, out: '0, pready: 1'b0, prdata: 32'h0000_0000, pslverr: 1'b0,
    lock_n: 1'b1, irq: 1'b0};

  cosc_state_t st_reg;
  cosc_state_t st_next;

  cosc_dly_if dly ();

  ////////////////////////////////////////////////////////////////////////////
  // helpers
  function automatic logic in_bank(input cosc_addr_t a, input cosc_addr_t base);
    logic [7:0] d;
    d = a - base;
    return (a >= base) && (d[1:0] == 2'b00) && (d[7:2] < 6'(NUM_OUT));
  endfunction : in_bank

  function automatic cosc_idx_t bank_idx(input cosc_addr_t a, input cosc_addr_t base);
    logic [7:0] d;
    d = a - base;
    return d[4:2];
  endfunction : bank_idx

  function automatic logic is_single(input cosc_addr_t a);
    return (a == ADDR_STATUS) || (a == ADDR_CTRL) || (a == ADDR_IRQ_STAT) ||
           (a == ADDR_IRQ_CLR) || (a == ADDR_IRQ_EN);
  endfunction : is_single

  ////////////////////////////////////////////////////////////////////////////
  // delay setting store
  cosc_dly_mem cosc_dly_mem_i
  (
    .clk     (clk),
    .sys_rst (sys_rst),
    .dly     (dly.mem)
  );

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    logic               acc;
    logic               wr;
    logic               cs_rise;
    logic               sync_act;
    logic               sync_fall;
    logic               cal_go;
    logic [NUM_EV-1:0]  ev;
    logic [7:0]         code;
    logic               muted;
    logic               pd;
    cosc_word_t         rdat;
    acc       = 1'b0;
    wr        = 1'b0;
    cs_rise   = 1'b0;
    sync_act  = 1'b0;
    sync_fall = 1'b0;
    cal_go    = 1'b0;
    ev        = '0;
    code      = 8'h00;
    muted     = 1'b0;
    pd        = 1'b0;
    rdat      = 32'h0000_0000;
    st_next   = st_reg;

    // pin synchronisers, edges read only from the second stage
    st_next.cs_s1   = cfg_cs_n;
    st_next.cs_s2   = st_reg.cs_s1;
    st_next.cs_prev = st_reg.cs_s2;
    st_next.sy_s1   = sync_pin;
    st_next.sy_s2   = st_reg.sy_s1;
    cs_rise         = st_reg.cs_s2 && !st_reg.cs_prev;

    // sync request from register bit or pin
    sync_act          = st_reg.ctrl[CTRL_ALIGN] || st_reg.sy_s2;
    st_next.sync_prev = sync_act;
    sync_fall         = st_reg.sync_prev && !sync_act;
    if (sync_fall)
      ev[EV_SYNC_DONE] = 1'b1;

    // calibration start at end of a framed transfer
    cal_go = cs_rise && ((st_reg.ctrl[CTRL_AUTOCAL] && st_reg.wrote) ||
                         st_reg.ctrl[CTRL_CAL]);
    if (cs_rise)
      st_next.wrote = 1'b0;

    // loop calibration and lock
    case (st_reg.loop)
      ST_CAL:
      begin
        if (st_reg.tmr == 12'h000)
        begin
          st_next.loop          = ST_ACQUIRE;
          st_next.tmr           = LOCK_CYCLES - 12'h001;
          st_next.ctrl[CTRL_CAL] = 1'b0;
          ev[EV_CAL_DONE]       = 1'b1;
        end
        else
          st_next.tmr = st_reg.tmr - 12'h001;
      end
      ST_ACQUIRE:
      begin
        if (st_reg.tmr == 12'h000)
        begin
          st_next.loop = ST_LOCKED;
          ev[EV_LOCK]  = 1'b1;
        end
        else
          st_next.tmr = st_reg.tmr - 12'h001;
      end
      ST_LOCKED: ;
      ST_UNLOCKED: ;
      default: st_next.loop = ST_UNLOCKED;
    endcase
    if (cal_go)
    begin
      st_next.loop = ST_CAL;
      st_next.tmr  = CAL_CYCLES - 12'h001;
      if (st_reg.loop == ST_LOCKED)
        ev[EV_UNLOCK] = 1'b1;
    end

    // apb slave, one wait state per access
    acc             = psel && penable && !st_reg.pready;
    wr              = acc && pwrite;
    st_next.pready  = acc;
    st_next.pslverr = 1'b0;
    st_next.prdata  = 32'h0000_0000;
    if (acc)
      st_next.pslverr = !(is_single(paddr) || in_bank(paddr, ADDR_CFG_BASE) ||
                          in_bank(paddr, ADDR_DLY_BASE));

    // register read mux
    if (paddr == ADDR_STATUS)
    begin
      rdat[STAT_LOCK]     = (st_reg.loop == ST_LOCKED);
      rdat[STAT_CAL_BUSY] = (st_reg.loop == ST_CAL);
    end
    else if (paddr == ADDR_CTRL)
      rdat[7:0] = st_reg.ctrl;
    else if (paddr == ADDR_IRQ_STAT)
      rdat[NUM_EV-1:0] = st_reg.irq_stat;
    else if (paddr == ADDR_IRQ_EN)
      rdat[NUM_EV-1:0] = st_reg.irq_en;
    else if (in_bank(paddr, ADDR_CFG_BASE))
      rdat[7:0] = st_reg.cfg[bank_idx(paddr, ADDR_CFG_BASE)];
    else if (in_bank(paddr, ADDR_DLY_BASE))
      rdat[7:0] = dly.rd_data;
    if (acc && !pwrite)
      st_next.prdata = rdat;

    // register writes, after hardware clears so a software set wins
    if (wr)
    begin
      if (paddr == ADDR_CTRL)
        st_next.ctrl = pwdata[7:0] & CTRL_MASK;
      else if (paddr == ADDR_IRQ_CLR)
        st_next.irq_stat = st_reg.irq_stat & ~pwdata[NUM_EV-1:0];
      else if (paddr == ADDR_IRQ_EN)
        st_next.irq_en = pwdata[NUM_EV-1:0] & EV_MASK;
      else if (in_bank(paddr, ADDR_CFG_BASE))
        st_next.cfg[bank_idx(paddr, ADDR_CFG_BASE)] = pwdata[7:0];
      if (paddr != ADDR_IRQ_CLR && paddr != ADDR_IRQ_EN)
        st_next.wrote = 1'b1;
    end

    // events set after the clear so a same-cycle event is kept
    st_next.irq_stat = st_next.irq_stat | ev;

    // per-output divider, delay and gating
    for (int i = 0; i < NUM_OUT; i++)
    begin
      code  = {4'h0, st_reg.cfg[i][CFG_DIV_LSB +: 4]};
      muted = (st_reg.loop == ST_CAL) && st_reg.cfg[i][CFG_MUTE_CAL];
      pd    = (st_reg.cfg[i][CFG_MODE_LSB +: 2] == MODE_PWR_DOWN);
      if (st_reg.cfg[i][CFG_SYNC_EN] && sync_act)
      begin
        st_next.cnt[i]  = 8'h00;
        st_next.hold[i] = 8'h00;
        st_next.ph[i]   = 1'b0;
      end
      else if (st_reg.cfg[i][CFG_SYNC_EN] && sync_fall)
      begin
        st_next.hold[i] = dly.active[i];
        st_next.cnt[i]  = 8'h00;
      end
      else if (st_reg.hold[i] != 8'h00)
        st_next.hold[i] = st_reg.hold[i] - 8'h01;
      else if (st_reg.cnt[i] == code)
      begin
        st_next.cnt[i] = 8'h00;
        st_next.ph[i]  = !st_reg.ph[i];
      end
      else
        st_next.cnt[i] = st_reg.cnt[i] + 8'h01;
      st_next.out[i] = st_next.ph[i] && !pd && !muted;
    end

    // outputs
    st_next.lock_n = (st_next.loop != ST_LOCKED);
    st_next.irq    = |(st_next.irq_stat & st_next.irq_en);
  end

  ////////////////////////////////////////////////////////////////////////////
  // delay store access
  assign dly.wr_en   = psel && penable && !st_reg.pready && pwrite && in_bank(paddr, ADDR_DLY_BASE);
  assign dly.wr_idx  = bank_idx(paddr, ADDR_DLY_BASE);
  assign dly.wr_data = pwdata[7:0];
  assign dly.rd_idx  = bank_idx(paddr, ADDR_DLY_BASE);
  assign dly.apply   = st_reg.ctrl[CTRL_ALIGN] || st_reg.sy_s2;

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge clk)
  begin
    if (sys_rst)
      st_reg <= ST_RST;
    else
      st_reg <= st_next;
  end

  ////////////////////////////////////////////////////////////////////////////
  // port drive
  assign pready            = st_reg.pready;
  assign prdata            = st_reg.prdata;
  assign pslverr           = st_reg.pslverr;
  assign clk_out           = st_reg.out;
  assign lock_n            = st_reg.lock_n;
  assign irq               = st_reg.irq;
  assign ref_gain_boost    = st_reg.ctrl[CTRL_BOOST];
  assign ref_input_lowpass = st_reg.ctrl[CTRL_LOWPASS];

endmodule : cosc_ctrl

/* File: common/cosc_pkg.sv */
// Purpose: shared constants and types of the clock output and sync control block
// Assumes: 100 MHz system clock, APB register access with 32-bit data
// Notes:   one prescaler output period is modelled as one system clock cycle
package cosc_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // sizes
  localparam int NUM_OUT = 5;
  localparam int NUM_EV  = 4;

  typedef logic [31:0]        cosc_word_t;
  typedef logic [7:0]         cosc_addr_t;
  typedef logic [7:0]         cosc_byte_t;
  typedef logic [2:0]         cosc_idx_t;
  typedef logic [NUM_OUT-1:0] cosc_outs_t;

  ////////////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam cosc_addr_t ADDR_STATUS   = 8'h00;
  localparam cosc_addr_t ADDR_CTRL     = 8'h04;
  localparam cosc_addr_t ADDR_CFG_BASE = 8'h08;
  localparam cosc_addr_t ADDR_DLY_BASE = 8'h1c;
  localparam cosc_addr_t ADDR_IRQ_STAT = 8'h30;
  localparam cosc_addr_t ADDR_IRQ_CLR  = 8'h34;
  localparam cosc_addr_t ADDR_IRQ_EN   = 8'h38;

  ////////////////////////////////////////////////////////////////////////////
  // field positions
  localparam int STAT_LOCK     = 0;
  localparam int STAT_CAL_BUSY = 1;
  localparam int CTRL_CAL      = 0;
  localparam int CTRL_AUTOCAL  = 1;
  localparam int CTRL_ALIGN    = 2;
  localparam int CTRL_BOOST    = 3;
  localparam int CTRL_LOWPASS  = 4;
  localparam int CFG_DIV_LSB   = 0;
  localparam int CFG_MODE_LSB  = 4;
  localparam int CFG_MUTE_CAL  = 6;
  localparam int CFG_SYNC_EN   = 7;
  localparam int EV_LOCK       = 0;
  localparam int EV_UNLOCK     = 1;
  localparam int EV_CAL_DONE   = 2;
  localparam int EV_SYNC_DONE  = 3;

  localparam logic [1:0] MODE_PWR_DOWN = 2'h2;
  localparam cosc_byte_t CTRL_MASK     = 8'h1f;
  localparam logic [NUM_EV-1:0] EV_MASK = 4'hf;

  ////////////////////////////////////////////////////////////////////////////
  // reset values
  localparam cosc_byte_t CTRL_RST    = 8'h02;
  localparam cosc_byte_t OUT_CFG_RST = 8'h80;
  localparam cosc_byte_t DLY_RST     = 8'h00;

  ////////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_MHZ      = 100;
  localparam int CAL_TIME_US  = 20;
  localparam int LOCK_TIME_US = 10;
  localparam logic [11:0] CAL_CYCLES  = 12'(CAL_TIME_US * CLK_MHZ);
  localparam logic [11:0] LOCK_CYCLES = 12'(LOCK_TIME_US * CLK_MHZ);

  // loop state
  typedef enum logic [1:0] {ST_UNLOCKED, ST_CAL, ST_ACQUIRE, ST_LOCKED} cosc_loop_t;

endpackage : cosc_pkg

/* File: common/cosc_dly_if.sv */
// Purpose: carrier between the control core and the delay setting store
// Assumes: both ends on the same clock
// Notes:   active holds the delays in force since the last sync
`timescale 1ns/1ps
interface cosc_dly_if;
  logic                               wr_en;
  logic [2:0]                         wr_idx;
  logic [7:0]                         wr_data;
  logic [2:0]                         rd_idx;
  logic [7:0]                         rd_data;
  logic                               apply;
  logic [cosc_pkg::NUM_OUT-1:0][7:0]  active;

  modport ctrl (output wr_en, output wr_idx, output wr_data, output rd_idx, output apply,
                input rd_data, input active);
  modport mem  (input wr_en, input wr_idx, input wr_data, input rd_idx, input apply,
                output rd_data, output active);
endinterface : cosc_dly_if

/* File: logic/cosc_dly_mem.sv */
// Purpose: written and active output delay settings
// Assumes: apply is high for the whole sync request
// Notes:   read data come from a register, one cycle after rd_idx
`timescale 1ns/1ps
module cosc_dly_mem
(
  input  wire logic clk,
  input  wire logic sys_rst,
  cosc_dly_if.mem   dly
);
  import cosc_pkg::*;

  typedef struct packed {
    logic [NUM_OUT-1:0][7:0] shadow;
    logic [NUM_OUT-1:0][7:0] active;
    cosc_byte_t              rd_data;
  } cosc_mem_t;

  cosc_mem_t mem_reg;
  cosc_mem_t mem_next;

  ////////////////////////////////////////////////////////////////////////////
  // write, copy to active while sync is requested, registered read
  always_comb
  begin
    mem_next = mem_reg;
    if (dly.wr_en && dly.wr_idx < 3'(NUM_OUT))
    begin
      mem_next.shadow[dly.wr_idx] = dly.wr_data;
    end
    if (dly.apply)
    begin
      mem_next.active = mem_reg.shadow;
    end
    mem_next.rd_data = (dly.rd_idx < 3'(NUM_OUT)) ? mem_reg.shadow[dly.rd_idx] : 8'h00;
  end

  always_ff @(posedge clk)
  begin
    if (sys_rst)
      mem_reg <= '{shadow: {NUM_OUT{DLY_RST}}, active: {NUM_OUT{DLY_RST}}, rd_data: 8'h00};
    else
      mem_reg <= mem_next;
  end

  assign dly.rd_data = mem_reg.rd_data;
  assign dly.active  = mem_reg.active;

endmodule : cosc_dly_mem

/* File: tb/cosc_ctrl_properties.sv */
// Purpose: port level checks of the clock control block
// Assumes: one clock domain, synchronous active-high reset
// Notes:   bound from the bench top file
`timescale 1ns/1ps
module cosc_ctrl_properties
(
  input wire logic                 clk,
  input wire logic                 sys_rst,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire cosc_pkg::cosc_addr_t paddr,
  input wire cosc_pkg::cosc_word_t pwdata,
  input wire logic                 pready,
  input wire cosc_pkg::cosc_word_t prdata,
  input wire logic                 pslverr,
  input wire logic                 cfg_cs_n,
  input wire logic                 sync_pin,
  input wire cosc_pkg::cosc_outs_t clk_out,
  input wire logic                 lock_n,
  input wire logic                 ref_gain_boost,
  input wire logic                 ref_input_lowpass,
  input wire logic                 irq
);
  import cosc_pkg::*;
  logic        cs_reg;
  logic [15:0] since_cs_reg;
  logic [1:0]  lock_hist_reg;
  cosc_word_t  wd_reg;
  ////////////////////////////////////////////////////////////////////////////
  // history of write data, lock pin and frame end
  always_ff @(posedge clk)
  begin
    wd_reg <= pwdata;
    lock_hist_reg <= {lock_hist_reg[0], lock_n};
    if (sys_rst)
    begin
      cs_reg <= 1'b1;
      since_cs_reg <= 16'h0;
    end
    else
    begin
      cs_reg <= cfg_cs_n;
      since_cs_reg <= (cfg_cs_n && !cs_reg) ? 16'h0 :
                      ((since_cs_reg == 16'hffff) ? since_cs_reg : since_cs_reg + 16'h1);
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // bus steps
  default clocking dc @(posedge clk);
  endclocking
  default disable iff (sys_rst);
  sequence s_taken;
    psel && penable && !pready;
  endsequence
  sequence s_answer;
    pready ##1 !pready;
  endsequence
  sequence s_ctrl_write;
    pready && pwrite && paddr == ADDR_CTRL && !pslverr;
  endsequence
  a_ready_follows: assert property (s_taken |=> s_answer)
    else $error("access phase not answered after one cycle");
  a_ready_cause: assert property (pready |-> $past(psel) && $past(penable) && !$past(pready))
    else $error("ready without a pending access");
  a_err_only_ready: assert property (pslverr |-> pready)
    else $error("error flag outside ready cycle");
  a_data_idle: assert property (!pready |-> prdata == '0)
    else $error("read data not zero outside ready cycle");
  a_err_map: assert property (pready |-> pslverr == (paddr[1:0] != 2'h0 || paddr > ADDR_IRQ_EN))
    else $error("error flag disagrees with address map");
  a_lock_status: assert property (pready && !pwrite && paddr == ADDR_STATUS && lock_n == lock_hist_reg[0]
    && lock_hist_reg[0] == lock_hist_reg[1] |-> prdata[STAT_LOCK] == !lock_n)
    else $error("lock status bit and lock pin disagree");
  a_pins_follow: assert property (s_ctrl_write |=> ref_gain_boost == wd_reg[CTRL_BOOST]
    && ref_input_lowpass == wd_reg[CTRL_LOWPASS])
    else $error("reference input pins do not follow control write");
  a_lock_wait: assert property ($fell(lock_n) |-> since_cs_reg >= 16'd3000)
    else $error("lock reported before calibration could finish");
endmodule : cosc_ctrl_properties

/* File: tb/cosc_rx_model.sv */
// Purpose: receiver of the output clocks, stamps rising edges
// Assumes: same clock as the block, one cycle per prescaler period
// Notes:   counts clear while clr is high and are unknown before the first clear, stamps run free
`timescale 1ns/1ps
module cosc_rx_model
(
  input  wire logic                 clk,
  input  wire logic                 clr,
  input  wire cosc_pkg::cosc_outs_t clk_out,
  output logic [31:0]               last_rise [cosc_pkg::NUM_OUT],
  output logic [15:0]               rises     [cosc_pkg::NUM_OUT]
);
  import cosc_pkg::*;
  logic [31:0] cyc_reg  = '0;
  cosc_outs_t  prev_reg = '0;
  // edge counts and stamps per output
  always @(posedge clk)
  begin
    cyc_reg <= cyc_reg + 32'h1;
    prev_reg <= clk_out;
    for (int i = 0; i < NUM_OUT; i++)
    begin
      if (clr) rises[i] <= '0;
      else if (clk_out[i] && !prev_reg[i]) rises[i] <= rises[i] + 16'h1;
      if (clk_out[i] && !prev_reg[i]) last_rise[i] <= cyc_reg;
    end
  end
endmodule : cosc_rx_model

/* File: tb/clock_output_sync_control_bench.sv */
// Purpose: self-checking bench of the clock control block
// Assumes: APB master tasks, receiver model on the output clocks
// Notes:   reads queue their expectation, a monitor compares at ready
`timescale 1ns/1ps
module clock_output_sync_control_bench;
  import cosc_pkg::*;
  typedef struct {logic err; cosc_word_t data; cosc_word_t mask;} cosc_note_t;
  logic        clk, sys_rst, psel, penable, pwrite, cfg_cs_n, sync_pin, rx_clr;
  logic        pready, pslverr, lock_n, ref_gain_boost, ref_input_lowpass, irq;
  cosc_addr_t  paddr;
  cosc_word_t  pwdata, prdata, rdata;
  cosc_outs_t  clk_out;
  logic [31:0] last_rise [NUM_OUT];
  logic [15:0] rises [NUM_OUT];
  logic [31:0] lfsr_q;
  logic [7:0]  dly1;
  int          failures = 0;
  int          cmp_count = 0;
  cosc_note_t  exp_q[$];
  cosc_note_t  note;

  cosc_ctrl cosc_ctrl_i (.clk(clk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr), .cfg_cs_n(cfg_cs_n),
    .sync_pin(sync_pin), .clk_out(clk_out), .lock_n(lock_n), .ref_gain_boost(ref_gain_boost),
    .ref_input_lowpass(ref_input_lowpass), .irq(irq));
  cosc_rx_model cosc_rx_model_i (.clk(clk), .clr(rx_clr), .clk_out(clk_out), .last_rise(last_rise), .rises(rises));

  ////////////////////////////////////////////////////////////////////////////
  // clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next

  task automatic results;
    if (failures == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : results

  task automatic chk(input cosc_word_t seen, input cosc_word_t want);
    cmp_count++;
    if (seen !== want)
    begin
      failures++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, want);
    end
  endtask : chk

  // one APB transfer, held until ready is sampled
  task automatic apb(input logic w, input cosc_addr_t a, input cosc_word_t d, input cosc_word_t m, input logic e);
    int n;
    exp_q.push_back('{e, d, m});
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    rdata = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      failures++;
      results();
    end
  endtask : apb

  task automatic wr(input cosc_addr_t a, input cosc_word_t d);
    apb(1'b1, a, d, '0, 1'b0);
  endtask : wr

  task automatic rd(input cosc_addr_t a, input cosc_word_t d, input cosc_word_t m);
    apb(1'b0, a, d, m, 1'b0);
  endtask : rd

  task automatic poll(input cosc_addr_t a, input cosc_word_t m, input cosc_word_t v);
    int n;
    n = 0;
    do
    begin
      rd(a, '0, '0);
      n++;
    end
    while ((rdata & m) !== v && n < 2000);
    if ((rdata & m) !== v)
    begin
      failures++;
      results();
    end
  endtask : poll

  task automatic pulse_clr;
    rx_clr <= 1'b1;
    @(posedge clk);
    rx_clr <= 1'b0;
  endtask : pulse_clr

  task automatic chk_phase;
    chk((last_rise[1] - last_rise[0]) & 32'h1f, 32'(dly1));
    chk((last_rise[2] - last_rise[0]) & 32'h1f, 32'h2);
  endtask : chk_phase

  // sync by pin or by the align bit, then spacing
  task automatic align(input logic by_pin);
    if (by_pin) sync_pin <= 1'b1;
    else wr(ADDR_CTRL, 32'h06);
    repeat (5) @(posedge clk);
    pulse_clr;
    repeat (50) @(posedge clk);
    chk(32'(rises[0]), 32'h0);
    chk(32'(rises[4] != 0), 32'h1);
    if (by_pin) sync_pin <= 1'b0;
    else wr(ADDR_CTRL, 32'h02);
    repeat (100) @(posedge clk);
    chk_phase;
  endtask : align

  // monitor: oldest note against each answer
  always @(posedge clk)
  begin
    if (pready === 1'b1 && exp_q.size() > 0)
    begin
      note = exp_q.pop_front();
      chk(32'(pslverr), 32'(note.err));
      if (!pwrite) chk(prdata & note.mask, note.data & note.mask);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    cfg_cs_n = 1'b1;
    sync_pin = 1'b0;
    rx_clr = 1'b0;
    lfsr_q = 32'h16ec;
    dly1 = 8'h02;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    rd(ADDR_CTRL, 32'h02, 32'hff);
    for (int i = 0; i < NUM_OUT; i++)
    begin
      rd(cosc_addr_t'(ADDR_CFG_BASE + 4 * i), 32'h80, 32'hff);
      rd(cosc_addr_t'(ADDR_DLY_BASE + 4 * i), 32'h00, 32'hff);
    end
    rd(ADDR_STATUS, 32'h0, 32'h3);
    chk(32'(lock_n), 32'h1);
    apb(1'b0, 8'h3c, '0, '0, 1'b1);
    apb(1'b1, 8'h05, '0, '0, 1'b1);
    wr(ADDR_IRQ_EN, 32'h5);
    // first frame, calibration after release
    cfg_cs_n <= 1'b0;
    wr(ADDR_CFG_BASE, 32'h8f);
    wr(ADDR_CFG_BASE + 8'h04, 32'h8f);
    wr(ADDR_CFG_BASE + 8'h08, 32'h8f);
    wr(ADDR_CFG_BASE + 8'h0c, 32'h4f);
    wr(ADDR_CFG_BASE + 8'h10, 32'h01);
    wr(ADDR_DLY_BASE + 8'h04, 32'h02);
    wr(ADDR_DLY_BASE + 8'h08, 32'h02);
    wr(ADDR_CTRL, 32'h02);
    cfg_cs_n <= 1'b1;
    poll(ADDR_STATUS, 32'h2, 32'h2);
    pulse_clr;
    repeat (400) @(posedge clk);
    chk(32'(rises[4] != 0), 32'h1);
    chk(32'(rises[3]), 32'h0);
    poll(ADDR_STATUS, 32'h1, 32'h1);
    chk(32'(lock_n), 32'h0);
    rd(ADDR_CTRL, 32'h02, 32'h03);
    rd(ADDR_IRQ_STAT, 32'h5, 32'hf);
    chk(32'(irq), 32'h1);
    wr(ADDR_IRQ_CLR, 32'h1);
    wr(ADDR_IRQ_EN, 32'h1);
    repeat (3) @(posedge clk);
    chk(32'(irq), 32'h0);
    rd(ADDR_IRQ_CLR, 32'h0, 32'hffffffff);
    wr(ADDR_IRQ_CLR, 32'hf);
    rd(ADDR_IRQ_STAT, 32'h0, 32'hf);
    wr(ADDR_IRQ_EN, 32'h8);
    align(1'b0);
    chk(32'(irq), 32'h1);
    // random delay waits for the next sync
    lfsr_q = lfsr_next(lfsr_q);
    wr(ADDR_DLY_BASE + 8'h04, {28'h0, lfsr_q[3:0]});
    repeat (100) @(posedge clk);
    chk_phase;
    dly1 = {4'h0, lfsr_q[3:0]};
    align(1'b1);
    // buffer off with divider running
    wr(ADDR_CFG_BASE, 32'haf);
    pulse_clr;
    repeat (100) @(posedge clk);
    chk(32'(rises[0]), 32'h0);
    wr(ADDR_CFG_BASE, 32'h8f);
    repeat (100) @(posedge clk);
    chk_phase;
    // second frame, calibrate bit written last
    cfg_cs_n <= 1'b0;
    wr(ADDR_CFG_BASE, 32'h8f);
    wr(ADDR_CTRL, 32'h01);
    rd(ADDR_STATUS, 32'h1, 32'h3);
    cfg_cs_n <= 1'b1;
    poll(ADDR_STATUS, 32'h2, 32'h2);
    poll(ADDR_CTRL, 32'h1, 32'h0);
    chk(32'(lock_n), 32'h1);
    poll(ADDR_STATUS, 32'h1, 32'h1);
    rd(ADDR_IRQ_STAT, 32'h2, 32'h2);
    // all reference input bit combinations
    for (int k = 0; k < 4; k++)
    begin
      wr(ADDR_CTRL, 32'(k << 3));
      repeat (2) @(posedge clk);
      chk(32'(ref_gain_boost), 32'(k & 1));
      chk(32'(ref_input_lowpass), 32'(k >> 1));
    end
    results();
  end
endmodule : clock_output_sync_control_bench

bind cosc_ctrl cosc_ctrl_properties cosc_ctrl_properties_i (.clk(clk), .sys_rst(sys_rst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
  .pslverr(pslverr), .cfg_cs_n(cfg_cs_n), .sync_pin(sync_pin), .clk_out(clk_out), .lock_n(lock_n),
  .ref_gain_boost(ref_gain_boost), .ref_input_lowpass(ref_input_lowpass), .irq(irq));
